// ### inc/hse_consts.svh
// Purpose: named constants of the hit stream encoder options block
// Assumes: word-indexed register port, 4-bit address
// Notes:   included by its bare name
`ifndef HSE_CONSTS_SVH
`define HSE_CONSTS_SVH
// ----------------------------------------
// register indexes
// ----------------------------------------
`define HSE_A_MERGE   4'h0
`define HSE_A_ENC     4'h1
`define HSE_A_EVEN    4'h2
`define HSE_A_ODD     4'h3
`define HSE_A_DUR     4'h4
`define HSE_A_COLEN   4'h5
`define HSE_A_TMO     4'h6
`define HSE_A_STAT    4'h7
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define HSE_MERGE_TAG  0
`define HSE_ENC_LIM    3:0
`define HSE_ENC_LIMEN  4
`define HSE_ENC_FILT   7
`define HSE_ENC_CUT    10:8
`define HSE_DUR_AEN    0
`define HSE_DUR_DEN    1
`define HSE_DUR_DLY    10:2
`define HSE_RST_TAG    1'h1
`define HSE_RST_ENC    11'h000
`define HSE_RST_MASK   16'h0000
`define HSE_RST_DUR    11'h003
`define HSE_RST_COLEN  16'hFFFF
`define HSE_RST_TMO    16'hFFFF
// ----------------------------------------
// codes
// ----------------------------------------
`define HSE_NOHIT      4'hF
`define HSE_ROW_TRUNC  8'hCC
`define HSE_ROW_TMO    8'hCD
`define HSE_ROW_FINE   8'hFE
`define HSE_NO_COL     6'h3F
`endif

// ### inc/hse_pkg.sv
// Purpose: types of the hit stream encoder options block
// Assumes: constants live in hse_consts.svh
// Notes:   whole module state is one packed struct
package hse_pkg;
  typedef enum logic [1:0] {
    HSE_IDLE = 2'h0,
    HSE_RUN  = 2'h1,
    HSE_DROP = 2'h2
  } hse_ev_t;

  typedef struct packed {
    logic        tag_en;
    logic        id_cap;
    logic [1:0]  chip_id;
    logic [10:0] enc_cfg;
    logic [15:0] even_mask;
    logic [15:0] odd_mask;
    logic [10:0] dur_cfg;
    logic [15:0] col_en;
    logic [15:0] tmo_thr;
    hse_ev_t     ev;
    logic [15:0] ev_cnt;
    logic [5:0]  cur_col;
    logic [7:0]  col_cnt;
    logic        trunc_seen;
    logic        pend_trunc;
    logic [5:0]  pend_col;
    logic        pend_tmo;
    logic [31:0] rdata;
    logic        rec_valid;
    logic [5:0]  rec_col;
    logic [7:0]  rec_row;
    logic        rec_last;
    logic [15:0] rec_map;
    logic [63:0] rec_frag;
    logic        blk_valid;
    logic [63:0] blk_data;
    logic        fine_hold;
    logic [8:0]  fine_cnt;
    logic [5:0]  fine_col;
    logic [63:0] fine_frag;
  } hse_state_t;
endpackage

// ### logic/hse_encoder.sv
// Purpose: hit encoder options: source tag, truncation, isolation filter, fine timing
// Assumes: inputs synchronous to ref_clk_i, register read data one cycle later
// Notes:   one record per quarter-core on the record port
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "hse_consts.svh"

//Contract
// - each emitted block holds data from this chip only.
// - two tag bits follow the new stream bit at block start.
// - tagging on after reset, off when software clears its enable.
// - tag bits are the two low bits of the strapped chip id.
// - with limit on, at most limit times four hits per core column.
// - excess hits dropped; row 204, last set, map 0000, duration 0000.
// - readout time reaching threshold drops rest, ends event, appends row 205.
// - filtered hit below duration cut dropped when no chosen neighbour hit.
// - neighbour search stays inside the same core column.
// - even columns use even mask, odd columns use odd mask.
// - companion pixel in the same row and pair is always a neighbour.
// - one global enable bit switches the filter for all columns.
// - truncation, then filter on survivors, then encoding; timeout later.
// - four 16-bit fine words per column, 5 arrival and 11 duration bits.
// - fine words stored and triggered like hits, latency may differ.
// - fine timing bits inverted before encoding.
// - sixteen 4-bit fragments, map of non-1111 fragments, then those fragments.
// - a bus that did not fire is left out entirely.
// - word bits: duration low byte, arrival 0, duration 10:8, arrival 4:1.
// - separate arrival and duration enables; 9-bit fine latency.
// - each column has its own fine timing enable bit.
// - map bit zero where value is 1111, one otherwise.
module hse_encoder #(
  parameter int NCOL = 16
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  chip_id_strap_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        event_start_i,
  input  wire logic        event_end_i,
  input  wire logic        hit_valid_i,
  input  wire logic [5:0]  hit_col_i,
  input  wire logic [7:0]  hit_row_i,
  input  wire logic [63:0] hit_tot_i,
  output logic             hit_ready_o,
  input  wire logic        fine_valid_i,
  input  wire logic [5:0]  fine_col_i,
  input  wire logic [3:0]  fine_fired_i,
  input  wire logic [19:0] fine_arrival_i,
  input  wire logic [43:0] fine_duration_i,
  output logic             fine_ready_o,
  output logic             rec_valid_o,
  input  wire logic        rec_ready_i,
  output logic      [5:0]  rec_col_o,
  output logic      [7:0]  rec_row_o,
  output logic             rec_last_o,
  output logic      [15:0] rec_map_o,
  output logic      [63:0] rec_frag_o,
  input  wire logic        stream_valid_i,
  input  wire logic        new_stream_bit_i,
  input  wire logic [62:0] stream_bits_i,
  output logic             blk_valid_o,
  output logic      [63:0] blk_data_o
);
  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (NCOL < 1 || NCOL > 16) begin : g_chk
    $error("hse_encoder: NCOL must be 1 to 16");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] hse_map(input logic [63:0] t);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      m[i] = (t[i*4 +: 4] != `HSE_NOHIT);
    end
    return m;
  endfunction

  function automatic logic [63:0] hse_trunc(input logic [63:0] t, input logic [7:0] budget);
    logic [63:0] o;
    logic [7:0]  c;
    o = t;
    c = 8'h00;
    for (int i = 0; i < 16; i++) begin
      if (t[i*4 +: 4] != `HSE_NOHIT) begin
        if (c < budget) begin
          c = c + 8'h01;
        end else begin
          o[i*4 +: 4] = `HSE_NOHIT;
        end
      end
    end
    return o;
  endfunction

  // neighbours by circular offset inside one quarter-core of this column
  function automatic logic [63:0] hse_filt(input logic [63:0] t, input logic [15:0] mask,
                                           input logic [2:0] cut);
    logic [63:0] o;
    logic [15:0] h;
    logic        nb;
    logic [3:0]  d;
    o = t;
    h = hse_map(t);
    for (int i = 0; i < 16; i++) begin
      nb = h[i ^ 1];
      for (int j = 0; j < 16; j++) begin
        d = 4'(j - i);
        if (j != i && mask[d] && h[j]) begin
          nb = 1'b1;
        end
      end
      if (h[i] && (t[i*4 +: 4] < {1'b0, cut}) && !nb) begin
        o[i*4 +: 4] = `HSE_NOHIT;
      end
    end
    return o;
  endfunction

  function automatic logic [7:0] hse_pop(input logic [15:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 16; i++) begin
      c = c + {7'h00, m[i]};
    end
    return c;
  endfunction

  // ----------------------------------------
  // fine timing packing
  // ----------------------------------------
  logic [63:0] fine_pack;
  logic [NCOL-1:0] col_on;

  for (genvar b = 0; b < 4; b++) begin : g_fine
    logic [4:0]  arr;
    logic [10:0] dur;
    logic [15:0] w;
    assign arr = fine_arrival_i[b*5 +: 5];
    assign dur = fine_duration_i[b*11 +: 11];
    assign w   = {arr[4:1], dur[10:8], arr[0], dur[7:0]};
    assign fine_pack[b*16 +: 16] = fine_fired_i[b] ? ~w : 16'hFFFF;
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  hse_pkg::hse_state_t s_r;
  hse_pkg::hse_state_t s_nxt;

  for (genvar c = 0; c < NCOL; c++) begin : g_col
    assign col_on[c] = s_r.col_en[c];
  end

  logic        out_free;
  logic        hit_take;
  logic        fine_take;
  logic [63:0] t_kept;
  logic [63:0] t_filt;
  logic [63:0] fine_msk;
  logic [7:0]  budget;
  logic [7:0]  lim4;
  logic [7:0]  base_cnt;
  logic        new_col;
  logic        fine_col_ok;

  assign out_free    = !s_r.rec_valid || rec_ready_i;
  assign hit_ready_o = (s_r.ev == hse_pkg::HSE_DROP) ||
                       (s_r.ev == hse_pkg::HSE_RUN && out_free && !s_r.pend_tmo &&
                        !s_r.pend_trunc && !(s_r.fine_hold && s_r.fine_cnt == 9'h000));
  assign fine_ready_o = !s_r.fine_hold;
  assign hit_take  = hit_valid_i && hit_ready_o;
  assign fine_take = fine_valid_i && !s_r.fine_hold;
  assign fine_col_ok = (fine_col_i < 6'(NCOL)) && col_on[fine_col_i[3:0]];

  always_comb begin
    new_col  = (hit_col_i != s_r.cur_col);
    base_cnt = new_col ? 8'h00 : s_r.col_cnt;
    lim4     = {2'b00, s_r.enc_cfg[`HSE_ENC_LIM], 2'b00};
    budget   = (base_cnt < lim4) ? lim4 - base_cnt : 8'h00;
    t_kept   = s_r.enc_cfg[`HSE_ENC_LIMEN] ? hse_trunc(hit_tot_i, budget) : hit_tot_i;
    t_filt   = !s_r.enc_cfg[`HSE_ENC_FILT] ? t_kept :
               hse_filt(t_kept, hit_col_i[0] ? s_r.odd_mask : s_r.even_mask,
                        s_r.enc_cfg[`HSE_ENC_CUT]);
    fine_msk = fine_pack;
    for (int b = 0; b < 4; b++) begin
      if (!s_r.dur_cfg[`HSE_DUR_AEN]) begin
        fine_msk[b*16 + 8]       = 1'b1;
        fine_msk[b*16 + 12 +: 4] = 4'hF;
      end
      if (!s_r.dur_cfg[`HSE_DUR_DEN]) begin
        fine_msk[b*16 +: 8]     = 8'hFF;
        fine_msk[b*16 + 9 +: 3] = 3'h7;
      end
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.blk_valid = 1'b0;
    if (!s_r.id_cap) begin
      s_nxt.chip_id = chip_id_strap_i;
      s_nxt.id_cap  = 1'b1;
    end
    // register port
    s_nxt.rdata = 32'h00000000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `HSE_A_MERGE: s_nxt.rdata = {31'h0, s_r.tag_en};
        `HSE_A_ENC:   s_nxt.rdata = {21'h0, s_r.enc_cfg};
        `HSE_A_EVEN:  s_nxt.rdata = {16'h0, s_r.even_mask};
        `HSE_A_ODD:   s_nxt.rdata = {16'h0, s_r.odd_mask};
        `HSE_A_DUR:   s_nxt.rdata = {21'h0, s_r.dur_cfg};
        `HSE_A_COLEN: s_nxt.rdata = {16'h0, s_r.col_en};
        `HSE_A_TMO:   s_nxt.rdata = {16'h0, s_r.tmo_thr};
        `HSE_A_STAT:  s_nxt.rdata = {12'h0, s_r.ev_cnt, s_r.ev, s_r.chip_id};
        default:      s_nxt.rdata = 32'h00000000;
      endcase
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        `HSE_A_MERGE: s_nxt.tag_en    = reg_wdata_i[`HSE_MERGE_TAG];
        `HSE_A_ENC:   s_nxt.enc_cfg   = reg_wdata_i[10:0];
        `HSE_A_EVEN:  s_nxt.even_mask = reg_wdata_i[15:0];
        `HSE_A_ODD:   s_nxt.odd_mask  = reg_wdata_i[15:0];
        `HSE_A_DUR:   s_nxt.dur_cfg   = reg_wdata_i[10:0];
        `HSE_A_COLEN: s_nxt.col_en    = reg_wdata_i[15:0];
        `HSE_A_TMO:   s_nxt.tmo_thr   = reg_wdata_i[15:0];
        default:      s_nxt.tag_en    = s_r.tag_en;
      endcase
    end
    // block framing
    if (stream_valid_i) begin
      s_nxt.blk_valid = 1'b1;
      s_nxt.blk_data  = s_r.tag_en ?
                        {new_stream_bit_i, s_r.chip_id, stream_bits_i[62:2]} :
                        {new_stream_bit_i, stream_bits_i};
    end
    // record handshake
    if (s_r.rec_valid && rec_ready_i) begin
      s_nxt.rec_valid = 1'b0;
    end
    // event state and timeout
    case (s_r.ev)
      hse_pkg::HSE_IDLE: begin
        s_nxt.ev_cnt = 16'h0000;
      end
      hse_pkg::HSE_RUN: begin
        s_nxt.ev_cnt = s_r.ev_cnt + 16'h0001;
        if (s_r.ev_cnt >= s_r.tmo_thr) begin
          s_nxt.ev       = hse_pkg::HSE_DROP;
          s_nxt.pend_tmo = 1'b1;
        end else if (event_end_i) begin
          s_nxt.ev = hse_pkg::HSE_IDLE;
        end
      end
      hse_pkg::HSE_DROP: begin
        if (event_end_i && !s_r.pend_tmo) begin
          s_nxt.ev = hse_pkg::HSE_IDLE;
        end
      end
      default: begin
        s_nxt.ev = hse_pkg::HSE_IDLE;
      end
    endcase
    if (event_start_i && s_r.ev == hse_pkg::HSE_IDLE) begin
      s_nxt.ev         = hse_pkg::HSE_RUN;
      s_nxt.ev_cnt     = 16'h0000;
      s_nxt.cur_col    = `HSE_NO_COL;
      s_nxt.col_cnt    = 8'h00;
      s_nxt.trunc_seen = 1'b0;
    end
    // fine timing capture and latency
    if (fine_take && fine_col_ok && fine_msk != 64'hFFFFFFFFFFFFFFFF) begin
      s_nxt.fine_hold = 1'b1;
      s_nxt.fine_cnt  = s_r.dur_cfg[`HSE_DUR_DLY];
      s_nxt.fine_col  = fine_col_i;
      s_nxt.fine_frag = fine_msk;
    end
    if (s_r.fine_hold && s_r.fine_cnt != 9'h000) begin
      s_nxt.fine_cnt = s_r.fine_cnt - 9'h001;
    end
    // record producer, trailers first
    if (out_free) begin
      if (s_r.pend_tmo) begin
        s_nxt.pend_tmo  = 1'b0;
        s_nxt.rec_valid = 1'b1;
        s_nxt.rec_col   = s_r.cur_col;
        s_nxt.rec_row   = `HSE_ROW_TMO;
        s_nxt.rec_last  = 1'b1;
        s_nxt.rec_map   = 16'h0000;
        s_nxt.rec_frag  = 64'h0000000000000000;
      end else if (s_r.pend_trunc) begin
        s_nxt.pend_trunc = 1'b0;
        s_nxt.rec_valid  = 1'b1;
        s_nxt.rec_col    = s_r.pend_col;
        s_nxt.rec_row    = `HSE_ROW_TRUNC;
        s_nxt.rec_last   = 1'b1;
        s_nxt.rec_map    = 16'h0000;
        s_nxt.rec_frag   = 64'h0000000000000000;
      end else if (s_r.fine_hold && s_r.fine_cnt == 9'h000) begin
        s_nxt.fine_hold = 1'b0;
        s_nxt.rec_valid = 1'b1;
        s_nxt.rec_col   = s_r.fine_col;
        s_nxt.rec_row   = `HSE_ROW_FINE;
        s_nxt.rec_last  = 1'b0;
        s_nxt.rec_map   = hse_map(s_r.fine_frag);
        s_nxt.rec_frag  = s_r.fine_frag;
      end
    end
    // hit path, data in a drop state is swallowed
    if (hit_take && s_r.ev == hse_pkg::HSE_RUN) begin
      s_nxt.cur_col = hit_col_i;
      s_nxt.col_cnt = base_cnt + hse_pop(hse_map(t_kept));
      if (new_col) begin
        s_nxt.trunc_seen = 1'b0;
      end
      if (t_kept != hit_tot_i && (new_col || !s_r.trunc_seen)) begin
        s_nxt.trunc_seen = 1'b1;
        s_nxt.pend_trunc = 1'b1;
        s_nxt.pend_col   = hit_col_i;
      end
      if (hse_map(t_filt) != 16'h0000) begin
        s_nxt.rec_valid = 1'b1;
        s_nxt.rec_col   = hit_col_i;
        s_nxt.rec_row   = hit_row_i;
        s_nxt.rec_last  = 1'b0;
        s_nxt.rec_map   = hse_map(t_filt);
        s_nxt.rec_frag  = t_filt;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_r            <= '0;
      s_r.tag_en     <= `HSE_RST_TAG;
      s_r.enc_cfg    <= `HSE_RST_ENC;
      s_r.even_mask  <= `HSE_RST_MASK;
      s_r.odd_mask   <= `HSE_RST_MASK;
      s_r.dur_cfg    <= `HSE_RST_DUR;
      s_r.col_en     <= `HSE_RST_COLEN;
      s_r.tmo_thr    <= `HSE_RST_TMO;
      s_r.ev         <= hse_pkg::HSE_IDLE;
      s_r.cur_col    <= `HSE_NO_COL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata_o = s_r.rdata;
  assign rec_valid_o = s_r.rec_valid;
  assign rec_col_o   = s_r.rec_col;
  assign rec_row_o   = s_r.rec_row;
  assign rec_last_o  = s_r.rec_last;
  assign rec_map_o   = s_r.rec_map;
  assign rec_frag_o  = s_r.rec_frag;
  assign blk_valid_o = s_r.blk_valid;
  assign blk_data_o  = s_r.blk_data;
endmodule
`default_nettype wire

// ### verification/hit_stream_encoder_options_tb_top.sv
// Purpose: self-checking bench of hse_encoder
// Assumes: 25 MHz clock, sync active-high reset
// Notes:   expected results queued by drivers
`timescale 1ns/1ps
`default_nettype none
`include "hse_consts.svh"
module hit_stream_encoder_options_tb_top;
  typedef struct packed {
    logic [5:0]  col;
    logic [7:0]  row;
    logic [15:0] map;
    logic [63:0] frag;
    logic        chk;
  } hse_exp_t;
  logic        ref_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic        event_start_i = 1'b0, event_end_i = 1'b0, hit_valid_i = 1'b0;
  logic        fine_valid_i = 1'b0, stream_valid_i = 1'b0, new_stream_bit_i = 1'b0;
  logic        stall = 1'b0, rd_pend = 1'b0;
  logic [1:0]  chip_id_strap_i = 2'h2;
  logic [3:0]  reg_addr_i = 4'h0, fine_fired_i = 4'h0;
  logic [5:0]  hit_col_i = 6'h0, fine_col_i = 6'h0, rec_col_o;
  logic [7:0]  hit_row_i = 8'h0, rec_row_o;
  logic [15:0] rec_map_o;
  logic [19:0] fine_arrival_i = 20'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic [43:0] fine_duration_i = 44'h0;
  logic [62:0] stream_bits_i = 63'h0;
  logic [63:0] hit_tot_i = 64'h0, rec_frag_o, blk_data_o;
  logic        hit_ready_o, fine_ready_o, rec_valid_o, rec_ready_i, rec_last_o, blk_valid_o;
  int          n_mismatch = 0, comparisons = 0, cyc = 0, seed = 32'hd60d;
  hse_exp_t    rq[$], e;
  logic [64:0] bq[$], dq[$];
  logic [3:0]  ra[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9};
  logic [31:0] rv[9] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h3, 32'hFFFF, 32'hFFFF, 32'h2, 32'h0};
  // ----------------------------------------
  // design and partner
  // ----------------------------------------
  hse_encoder #(.NCOL(16)) i_hse_encoder (.ref_clk_i, .rst_i, .chip_id_strap_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .event_start_i, .event_end_i,
    .hit_valid_i, .hit_col_i, .hit_row_i, .hit_tot_i, .hit_ready_o, .fine_valid_i,
    .fine_col_i, .fine_fired_i, .fine_arrival_i, .fine_duration_i, .fine_ready_o,
    .rec_valid_o, .rec_ready_i, .rec_col_o, .rec_row_o, .rec_last_o, .rec_map_o,
    .rec_frag_o, .stream_valid_i, .new_stream_bit_i, .stream_bits_i, .blk_valid_o, .blk_data_o);
  hse_daq_sink i_hse_daq_sink (.ref_clk_i, .rst_i, .rec_valid_i(rec_valid_o),
    .stall_i(stall), .rec_ready_o(rec_ready_i));
  initial forever #20 ref_clk_i = ~ref_clk_i;
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input logic [64:0] seen, input logic [64:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    stall <= $random(seed) % 3 == 0;
    rd_pend <= reg_rd_i && !rst_i;
    if (rd_pend) check(reg_rdata_o, dq.pop_front());
    if (blk_valid_o) check(blk_data_o, bq.pop_front());
    if (rec_valid_o && rec_ready_i) begin
      if (rq.size() == 0) check(rec_row_o, 65'hX);
      else begin
        e = rq.pop_front();
        check(rec_col_o, e.col);
        check(rec_row_o, e.row);
        check(rec_map_o, e.map);
        if (e.chk) check({rec_last_o, rec_frag_o},
                         {(e.row inside {`HSE_ROW_TRUNC, `HSE_ROW_TMO}), e.frag});
      end
    end
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    if (!w) dq.push_back(d);
    @(posedge ref_clk_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= w ? d : 32'h0;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
  endtask
  task automatic ev(input logic s);
    @(posedge ref_clk_i);
    event_start_i <= s;
    event_end_i <= !s;
    @(posedge ref_clk_i);
    event_start_i <= 1'b0;
    event_end_i <= 1'b0;
  endtask
  task automatic blk(input logic tag);
    logic [62:0] b;
    logic n;
    b = 63'({$random(seed), $random(seed)});
    n = 1'($random(seed));
    bq.push_back(tag ? {n, 2'h2, b[62:2]} : {n, b});
    @(posedge ref_clk_i);
    stream_valid_i <= 1'b1;
    new_stream_bit_i <= n;
    stream_bits_i <= b;
    @(posedge ref_clk_i);
    stream_valid_i <= 1'b0;
  endtask
  task automatic hit(input logic [5:0] c, input logic [63:0] t, input logic [15:0] m);
    int n = 0;
    logic [63:0] f;
    for (int j = 0; j < 16; j++) f[4*j +: 4] = m[j] ? t[4*j +: 4] : 4'hF;
    if (m != 16'h0) rq.push_back('{c, 8'h05, m, f, 1'b1});
    @(posedge ref_clk_i);
    hit_valid_i <= 1'b1;
    hit_col_i <= c;
    hit_row_i <= 8'h05;
    hit_tot_i <= t;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (!hit_ready_o && n < 200);
    if (n >= 200) n_mismatch++;
    hit_valid_i <= 1'b0;
  endtask
  task automatic fine(input logic [5:0] c, input logic [3:0] f, input logic [15:0] f1,
                      input logic en);
    logic [19:0] a;
    logic [43:0] d;
    logic [63:0] fr;
    logic [15:0] w, m;
    int n = 0;
    a = 20'($random(seed));
    d = 44'({$random(seed), $random(seed)});
    fr = '1;
    for (int b = 0; b < 4; b++) begin
      w = {a[5*b+1 +: 4], d[11*b+8 +: 3], a[5*b], d[11*b +: 8]};
      if (f[b]) fr[16*b +: 16] = ~w | f1;
    end
    for (int j = 0; j < 16; j++) m[j] = fr[4*j +: 4] != 4'hF;
    if (m != 16'h0 && en) rq.push_back('{c, `HSE_ROW_FINE, m, fr, 1'b1});
    @(posedge ref_clk_i);
    fine_valid_i <= 1'b1;
    fine_col_i <= c;
    fine_fired_i <= f;
    fine_arrival_i <= a;
    fine_duration_i <= d;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (!fine_ready_o && n < 200);
    if (n >= 200) n_mismatch++;
    fine_valid_i <= 1'b0;
  endtask
  task automatic drain(input string s);
    int n = 0;
    while ((rq.size() + bq.size() + dq.size()) != 0 && n < 500) begin
      @(posedge ref_clk_i);
      n++;
    end
    repeat (12) @(posedge ref_clk_i);
    check(rq.size() + bq.size() + dq.size(), 0);
    if (s != "") $display("test %s done", s);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    acc(1'b1, 4'h9, 32'hFFFF);
    for (int i = 0; i < 9; i++) acc(1'b0, ra[i], rv[i]);
    drain("reset values");
    blk(1'b1);
    blk(1'b1);
    acc(1'b1, 4'h0, 32'h0);
    acc(1'b0, 4'h0, 32'h0);
    blk(1'b0);
    acc(1'b1, 4'h0, 32'h1);
    blk(1'b1);
    drain("source tag");
    acc(1'b1, 4'h1, 32'h11);
    ev(1'b1);
    hit(6'h2, 64'h0, 16'h000F);
    rq.push_back('{6'h2, `HSE_ROW_TRUNC, 16'h0, 64'h0, 1'b1});
    hit(6'h2, 64'h0, 16'h0);
    hit(6'h3, 64'hFFFF_FFFF_FFFF_FF00, 16'h0003);
    ev(1'b0);
    drain("column limit");
    acc(1'b1, 4'h1, 32'h480);
    acc(1'b0, 4'h1, 32'h480);
    ev(1'b1);
    hit(6'h2, 64'hFFFF_FFFF_FFF7_11F1, 16'h001C);
    acc(1'b1, 4'h2, 32'h4004);
    hit(6'h4, 64'hFFFF_FFF1_F1FF_FFFF, 16'h0140);
    hit(6'h5, 64'hFFFF_FFF1_F1FF_FFFF, 16'h0);
    acc(1'b1, 4'h1, 32'h491);
    hit(6'h6, 64'hF7FF_FFFF_F777_FFF1, 16'h0070);
    rq.push_back('{6'h6, `HSE_ROW_TRUNC, 16'h0, 64'h0, 1'b1});
    ev(1'b0);
    drain("isolation filter");
    acc(1'b1, 4'h1, 32'h0);
    ev(1'b1);
    acc(1'b1, 4'h4, 32'h00B);
    fine(6'h1, 4'h5, 16'h0, 1'b1);
    acc(1'b1, 4'h4, 32'h00A);
    fine(6'h2, 4'hA, 16'hF100, 1'b1);
    acc(1'b1, 4'h4, 32'h009);
    fine(6'h1, 4'h3, 16'h0EFF, 1'b1);
    acc(1'b1, 4'h5, 32'h0);
    fine(6'h3, 4'hF, 16'h0, 1'b0);
    acc(1'b1, 4'h5, 32'hFFFF);
    acc(1'b1, 4'h4, 32'h3);
    ev(1'b0);
    drain("fine timing");
    acc(1'b1, 4'h6, 32'h5);
    rq.push_back('{`HSE_NO_COL, `HSE_ROW_TMO, 16'h0, 64'h0, 1'b1});
    ev(1'b1);
    drain("");
    hit(6'h2, 64'h0, 16'h0);
    ev(1'b0);
    acc(1'b1, 4'h6, 32'hFFFF);
    drain("readout timeout");
    acc(1'b1, 4'h0, 32'h0);
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    acc(1'b0, 4'h0, 32'h1);
    blk(1'b1);
    drain("second reset");
    final_report();
  end
endmodule
bind hse_encoder hse_encoder_props #(.NCOL(NCOL)) i_hse_encoder_props (.ref_clk_i, .rst_i,
  .reg_rd_i, .reg_rdata_o, .stream_valid_i, .new_stream_bit_i, .stream_bits_i, .blk_valid_o,
  .blk_data_o, .rec_valid_o, .rec_ready_i, .rec_row_o, .rec_last_o, .rec_map_o, .rec_frag_o);
`default_nettype wire

// ### verification/hse_daq_sink.sv
// Purpose: acquisition side taking records
// Assumes: stall pattern from the bench
// Notes:   ready is combinational
`timescale 1ns/1ps
`default_nettype none
module hse_daq_sink (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic rec_valid_i,
  input  wire logic stall_i,
  output logic      rec_ready_o
);
  // takes a record whenever out of reset and not stalled
  assign rec_ready_o = !rst_i && !stall_i;
endmodule
`default_nettype wire

// ### verification/hse_encoder_props.sv
// Purpose: port assertions of hse_encoder
// Assumes: bound from the bench top
// Notes:   one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "hse_consts.svh"
module hse_encoder_props #(
  parameter int NCOL = 16
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        stream_valid_i,
  input wire logic        new_stream_bit_i,
  input wire logic [62:0] stream_bits_i,
  input wire logic        blk_valid_o,
  input wire logic [63:0] blk_data_o,
  input wire logic        rec_valid_o,
  input wire logic        rec_ready_i,
  input wire logic [7:0]  rec_row_o,
  input wire logic        rec_last_o,
  input wire logic [15:0] rec_map_o,
  input wire logic [63:0] rec_frag_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [15:0] frag_map;
  logic [62:0] bits_q;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      frag_map[i] = rec_frag_o[4*i +: 4] != `HSE_NOHIT;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    bits_q <= stream_bits_i;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_rdata_quiet: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside answer cycle");
  a_blk_follow: assert property (
    stream_valid_i |=> blk_valid_o && blk_data_o[63] == $past(new_stream_bit_i))
    else $error("block missing or new stream bit wrong");
  a_blk_only: assert property (!stream_valid_i |=> !blk_valid_o)
    else $error("block without stream input");
  a_blk_payload: assert property (
    blk_valid_o |-> blk_data_o[60:0] == bits_q[62:2] || blk_data_o[62:0] == bits_q)
    else $error("block payload misplaced");
  a_trunc_mark: assert property (
    rec_valid_o && rec_row_o == `HSE_ROW_TRUNC |-> rec_last_o && rec_map_o == 16'h0
      && rec_frag_o == 64'h0)
    else $error("column trailer malformed");
  a_tmo_mark: assert property (
    rec_valid_o && rec_row_o == `HSE_ROW_TMO |-> rec_last_o && rec_map_o == 16'h0)
    else $error("timeout trailer malformed");
  a_rec_hold: assert property (rec_valid_o && !rec_ready_i |=> rec_valid_o
    && $stable(rec_row_o) && $stable(rec_map_o) && $stable(rec_frag_o))
    else $error("record changed while stalled");
  a_fine_map: assert property (
    rec_valid_o && rec_row_o == `HSE_ROW_FINE |-> !rec_last_o && rec_map_o == frag_map)
    else $error("fine map disagrees with fragments");
  a_rec_some: assert property (
    rec_valid_o && rec_row_o < `HSE_ROW_TRUNC |-> rec_map_o != 16'h0)
    else $error("empty record emitted");
endmodule
`default_nettype wire
